// *** src/cell_alert_pkg.sv ***
package cell_alert_pkg;
   // ==========================================
   // sizes
   localparam int NUM_CELLS = 14;
   localparam int NUM_AUX = 6;
   localparam int DATA_W = 16;
   localparam int IDX_W = 4;
   localparam int MSM_W = 14;
   // ==========================================
   // reset values
   localparam logic [MSM_W-1:0] MISMATCH_THR_RST = 14'h3FFF;
   localparam logic [DATA_W-1:0] OV_THR_RST = 16'hFFFF;
   localparam logic [DATA_W-1:0] UV_THR_RST = 16'h0000;
   localparam logic [NUM_CELLS-1:0] CELL_EN_RST = 14'h0000;
   localparam logic [NUM_AUX-1:0] AUX_EN_RST = 6'h00;
   localparam logic [DATA_W-1:0] SUM_RST = 16'h0000;
   localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
   // ==========================================
   // primary status field positions
   localparam int ST_CELL_OV = 0;
   localparam int ST_CELL_UV = 1;
   localparam int ST_BLK_OV = 2;
   localparam int ST_BLK_UV = 3;
   localparam int ST_AUX_OV = 4;
   localparam int ST_AUX_UV = 5;
   localparam int ST_MSMTCH = 6;
   localparam int ST_W = 7;
   // alert summary field positions
   localparam int SUM_ADC_OV = 0;
   localparam int SUM_ADC_UV = 1;
   localparam int SUM_CMP_OV = 2;
   localparam int SUM_CMP_UV = 3;
   localparam int SUM_ADC_AUX_OV = 4;
   localparam int SUM_ADC_AUX_UV = 5;
   localparam int SUM_CMP_AUX_OV = 6;
   localparam int SUM_CMP_AUX_UV = 7;
   localparam int SUM_W = 8;

   // set/clear threshold group for one hysteretic path
   typedef struct packed {
      logic [DATA_W-1:0] ov_set;
      logic [DATA_W-1:0] ov_clr;
      logic [DATA_W-1:0] uv_set;
      logic [DATA_W-1:0] uv_clr;
   } hyst_thr_t;

   // comparator threshold pair (no hysteresis)
   typedef struct packed {
      logic [DATA_W-1:0] ov;
      logic [DATA_W-1:0] uv;
   } cmp_thr_t;

   // one completed acquisition
   typedef struct packed {
      logic done;
      logic [NUM_CELLS-1:0][DATA_W-1:0] cell_raw;
      logic [NUM_CELLS-1:0][DATA_W-1:0] cell_filt;
      logic [NUM_CELLS-1:0][DATA_W-1:0] cell_cmp;
      logic [DATA_W-1:0] block_v;
      logic [NUM_AUX-1:0][DATA_W-1:0] aux_adc;
      logic [NUM_AUX-1:0][DATA_W-1:0] aux_cmp;
   } acq_t;
endpackage

// *** src/cell_alert_statistics.sv ***
`timescale 1ns/1ps
// Behaviour
// RULE1: cell/block alerts only for inputs enabled in ov/uv enable masks
// RULE2: adc and comparator ov flags set above their ov thresholds
// RULE3: adc and comparator uv flags set below uv thresholds, separate registers
// RULE4: adc flags clear past separate clear threshold; comparator by same threshold
// RULE5: strict compares; equality leaves flags unchanged
// RULE6: adc ov/uv summaries are or of per-cell adc flags
// RULE7: comparator ov/uv summaries are or of per-cell comparator flags
// RULE8: status cell ov/uv is or of adc and comparator summaries, to alert out
// RULE9: block ov/uv status from block voltage vs block set thresholds
// RULE10: each alert maskable from alert output without touching its flag
// RULE11: mismatch alert when max minus min exceeds 14-bit threshold
// RULE12: mismatch alert clears on next acquisition not exceeding threshold
// RULE13: mismatch threshold resets to all ones, disabling the alert; code still alerts when max minus min exceeds 16383
// RULE14: record min and max cell indices, lowest index wins ties
// RULE15: no enabled cells keeps min, max and sum unchanged
// RULE16: filtered select picks filtered or raw data for min, max, sum
// RULE17: polarity select limits min/max and mismatch to like channels
// RULE18: sum is 16-bit total of all enabled cells, any polarity
// RULE19: aux alerts only for aux channels enabled in aux ov/uv masks
// RULE20: per-aux reference select picks ratiometric or absolute thresholds
// RULE21: aux ov above set, uv below; adc clears by clear thresholds
// RULE22: ratiometric aux ov means undertemp, uv means overtemp
// RULE23: status aux bits are or of adc and comparator aux summaries
// RULE24: bipolar cells use bipolar set and clear thresholds
// RULE25: everything updates together once per acquisition and holds between; alert out and data check track status_mask every cycle
module cell_alert_statistics
   import cell_alert_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // acquisition results, already calibrated
   input wire acq_t acq,
   // cell configuration
   input wire logic [NUM_CELLS-1:0] cell_enable,
   input wire logic [NUM_CELLS-1:0] cell_bipolar,
   input wire logic [NUM_CELLS-1:0] cell_ov_alert_enable,
   input wire logic [NUM_CELLS-1:0] cell_uv_alert_enable,
   input wire logic block_ov_alert_enable,
   input wire logic block_uv_alert_enable,
   input wire hyst_thr_t cell_thr,
   input wire hyst_thr_t bipolar_thr,
   input wire hyst_thr_t block_thr,
   input wire cmp_thr_t comparator_cell_thr,
   // aux configuration
   input wire logic [NUM_AUX-1:0] aux_enable,
   input wire logic [NUM_AUX-1:0] aux_ov_alert_enable,
   input wire logic [NUM_AUX-1:0] aux_uv_alert_enable,
   input wire logic [NUM_AUX-1:0] aux_reference_select,
   input wire hyst_thr_t aux_ratio_thr,
   input wire hyst_thr_t aux_abs_thr,
   input wire cmp_thr_t comparator_aux_ratio_thr,
   input wire cmp_thr_t comparator_aux_abs_thr,
   // statistics configuration
   input wire logic filtered_read_select,
   input wire logic statistics_polarity_select,
   // register bus
   input wire logic [3:0] reg_addr,
   input wire logic [MSM_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [MSM_W-1:0] reg_rdata,
   // alert masks and outputs
   input wire logic [ST_W-1:0] status_mask,
   output logic [NUM_CELLS-1:0] adc_cell_ov_flags,
   output logic [NUM_CELLS-1:0] adc_cell_uv_flags,
   output logic [NUM_CELLS-1:0] comparator_cell_ov_flags,
   output logic [NUM_CELLS-1:0] comparator_cell_uv_flags,
   output logic [NUM_AUX-1:0] adc_aux_ov_flags,
   output logic [NUM_AUX-1:0] adc_aux_uv_flags,
   output logic [NUM_AUX-1:0] comparator_aux_ov_flags,
   output logic [NUM_AUX-1:0] comparator_aux_uv_flags,
   output logic [SUM_W-1:0] alert_summary_register,
   output logic [ST_W-1:0] primary_status_register,
   output logic hw_alert_out,
   output logic [ST_W-1:0] data_check_alerts,
   output logic [IDX_W-1:0] lowest_cell_index,
   output logic [IDX_W-1:0] highest_cell_index,
   output logic [DATA_W-1:0] cell_sum
);
   // ==========================================
   // hysteresis flag update helper
   function automatic logic hyst_next(input logic cur, input logic en, input logic is_ov,
                                      input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] set_t,
                                      input logic [DATA_W-1:0] clr_t);
      logic res;
      res = cur;
      if (!en) begin
         res = 1'b0;
      end else if (is_ov) begin
         if (v > set_t) res = 1'b1;
         else if (v < clr_t) res = 1'b0;
      end else begin
         if (v < set_t) res = 1'b1;
         else if (v > clr_t) res = 1'b0;
      end
      return res;
   endfunction

   // ==========================================
   // state
   logic [NUM_CELLS-1:0] aov_ff, auv_ff, cov_ff, cuv_ff;
   logic [NUM_AUX-1:0] xaov_ff, xauv_ff, xcov_ff, xcuv_ff;
   logic blk_ov_ff, blk_uv_ff, msm_ff;
   logic [MSM_W-1:0] mismatch_threshold_ff;
   logic [IDX_W-1:0] min_idx_ff, max_idx_ff;
   logic [DATA_W-1:0] sum_ff;
   logic [SUM_W-1:0] summ_ff;
   logic [ST_W-1:0] stat_ff, dcb_ff;
   logic alert_ff;
   logic [MSM_W-1:0] rdata_ff;

   logic [NUM_CELLS-1:0] nxt_aov, nxt_auv, nxt_cov, nxt_cuv;
   logic [NUM_AUX-1:0] nxt_xaov, nxt_xauv, nxt_xcov, nxt_xcuv;

   // ==========================================
   // cell alerts
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
         wire hyst_thr_t thr = cell_bipolar[gi] ? bipolar_thr : cell_thr; // RULE24
         wire logic en_ov = cell_enable[gi] & cell_ov_alert_enable[gi]; // RULE1
         wire logic en_uv = cell_enable[gi] & cell_uv_alert_enable[gi]; // RULE1
         // RULE2 RULE3 RULE4 RULE5
         assign nxt_aov[gi] = hyst_next(aov_ff[gi], en_ov, 1'b1, acq.cell_raw[gi],
                                        thr.ov_set, thr.ov_clr);
         assign nxt_auv[gi] = hyst_next(auv_ff[gi], en_uv, 1'b0, acq.cell_raw[gi],
                                        thr.uv_set, thr.uv_clr);
         // comparator clears by recrossing its own threshold
         assign nxt_cov[gi] = hyst_next(cov_ff[gi], en_ov, 1'b1, acq.cell_cmp[gi],
                                        comparator_cell_thr.ov, comparator_cell_thr.ov);
         assign nxt_cuv[gi] = hyst_next(cuv_ff[gi], en_uv, 1'b0, acq.cell_cmp[gi],
                                        comparator_cell_thr.uv, comparator_cell_thr.uv);
      end
      // ==========================================
      // aux alerts; ratiometric ov is undertemp, uv is overtemp
      for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
         wire hyst_thr_t thr = aux_reference_select[gi] ? aux_ratio_thr : aux_abs_thr; // RULE20
         wire cmp_thr_t cthr = aux_reference_select[gi] ? comparator_aux_ratio_thr :
                                                          comparator_aux_abs_thr; // RULE20
         wire logic en_ov = aux_enable[gi] & aux_ov_alert_enable[gi]; // RULE19
         wire logic en_uv = aux_enable[gi] & aux_uv_alert_enable[gi]; // RULE19
         // RULE21 RULE22
         assign nxt_xaov[gi] = hyst_next(xaov_ff[gi], en_ov, 1'b1, acq.aux_adc[gi],
                                         thr.ov_set, thr.ov_clr);
         assign nxt_xauv[gi] = hyst_next(xauv_ff[gi], en_uv, 1'b0, acq.aux_adc[gi],
                                         thr.uv_set, thr.uv_clr);
         assign nxt_xcov[gi] = hyst_next(xcov_ff[gi], en_ov, 1'b1, acq.aux_cmp[gi],
                                         cthr.ov, cthr.ov);
         assign nxt_xcuv[gi] = hyst_next(xcuv_ff[gi], en_uv, 1'b0, acq.aux_cmp[gi],
                                         cthr.uv, cthr.uv);
      end
   endgenerate

   // ==========================================
   // block alerts
   wire logic nxt_blk_ov = hyst_next(blk_ov_ff, block_ov_alert_enable, 1'b1, acq.block_v,
                                     block_thr.ov_set, block_thr.ov_clr); // RULE9
   wire logic nxt_blk_uv = hyst_next(blk_uv_ff, block_uv_alert_enable, 1'b0, acq.block_v,
                                     block_thr.uv_set, block_thr.uv_clr); // RULE9

   // ==========================================
   // statistics scan, lowest index wins ties by strict compare
   logic [IDX_W-1:0] nxt_min_idx, nxt_max_idx;
   logic [DATA_W-1:0] nxt_sum, vmin, vmax;
   logic any_like, any_en;
   always_comb begin
      logic [DATA_W-1:0] v;
      v = '0;
      nxt_min_idx = IDX_RST;
      nxt_max_idx = IDX_RST;
      nxt_sum = SUM_RST;
      vmin = '0;
      vmax = '0;
      any_like = 1'b0;
      any_en = 1'b0;
      for (int i = 0; i < NUM_CELLS; i++) begin
         v = filtered_read_select ? acq.cell_filt[i] : acq.cell_raw[i]; // RULE16
         if (cell_enable[i]) begin
            any_en = 1'b1;
            nxt_sum = DATA_W'(nxt_sum + v); // RULE18
            if (cell_bipolar[i] == statistics_polarity_select) begin // RULE17
               if (!any_like || ($signed(v) < $signed(vmin))) begin // RULE14
                  vmin = v;
                  nxt_min_idx = IDX_W'(i + 1);
               end
               if (!any_like || ($signed(v) > $signed(vmax))) begin // RULE14
                  vmax = v;
                  nxt_max_idx = IDX_W'(i + 1);
               end
               any_like = 1'b1;
            end
         end
      end
   end
   wire logic [DATA_W:0] spread = {vmax[DATA_W-1], vmax} - {vmin[DATA_W-1], vmin};
   wire logic nxt_msm = any_like && (spread > {3'h0, mismatch_threshold_ff}); // RULE11 RULE12

   // ==========================================
   // summaries and status
   wire logic [SUM_W-1:0] nxt_summ = {|nxt_xcuv, |nxt_xcov, |nxt_xauv, |nxt_xaov,
                                      |nxt_cuv, |nxt_cov, |nxt_auv, |nxt_aov}; // RULE6 RULE7
   wire logic [ST_W-1:0] nxt_stat = {nxt_msm,
      nxt_summ[SUM_ADC_AUX_UV] | nxt_summ[SUM_CMP_AUX_UV],
      nxt_summ[SUM_ADC_AUX_OV] | nxt_summ[SUM_CMP_AUX_OV], // RULE23
      nxt_blk_uv, nxt_blk_ov,
      nxt_summ[SUM_ADC_UV] | nxt_summ[SUM_CMP_UV],
      nxt_summ[SUM_ADC_OV] | nxt_summ[SUM_CMP_OV]}; // RULE8
   wire logic [ST_W-1:0] stat_unmasked = stat_ff & ~status_mask; // RULE10

   // ==========================================
   // register bus: offset 0 mismatch threshold, offset 1 status
   localparam logic [3:0] ADDR_MSM = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h1;
   localparam logic [3:0] ADDR_IDX = 4'h2;
   localparam logic [3:0] ADDR_SUM = 4'h3;
   wire logic [MSM_W-1:0] rd_mux =
      (reg_addr == ADDR_MSM) ? mismatch_threshold_ff :
      (reg_addr == ADDR_STAT) ? {{(MSM_W-ST_W){1'b0}}, stat_ff} :
      (reg_addr == ADDR_IDX) ? {6'h00, max_idx_ff, min_idx_ff} :
      (reg_addr == ADDR_SUM) ? sum_ff[MSM_W-1:0] : '0;

   // ==========================================
   // registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mismatch_threshold_ff <= MISMATCH_THR_RST; // RULE13
         rdata_ff <= '0;
      end else begin
         if (reg_wr && reg_addr == ADDR_MSM) mismatch_threshold_ff <= reg_wdata;
         rdata_ff <= reg_rd ? rd_mux : '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         {aov_ff, auv_ff, cov_ff, cuv_ff} <= '0;
         {xaov_ff, xauv_ff, xcov_ff, xcuv_ff} <= '0;
         {blk_ov_ff, blk_uv_ff, msm_ff} <= '0;
         summ_ff <= '0;
         stat_ff <= '0;
      end else if (acq.done) begin // RULE25
         {aov_ff, auv_ff, cov_ff, cuv_ff} <= {nxt_aov, nxt_auv, nxt_cov, nxt_cuv};
         {xaov_ff, xauv_ff, xcov_ff, xcuv_ff} <= {nxt_xaov, nxt_xauv, nxt_xcov, nxt_xcuv};
         {blk_ov_ff, blk_uv_ff, msm_ff} <= {nxt_blk_ov, nxt_blk_uv, nxt_msm};
         summ_ff <= nxt_summ;
         stat_ff <= nxt_stat;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         min_idx_ff <= IDX_RST;
         max_idx_ff <= IDX_RST;
         sum_ff <= SUM_RST;
      end else if (acq.done && any_en) begin // RULE15
         if (any_like) begin
            min_idx_ff <= nxt_min_idx;
            max_idx_ff <= nxt_max_idx;
         end
         sum_ff <= nxt_sum;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         alert_ff <= 1'b0;
         dcb_ff <= '0;
      end else begin
         alert_ff <= |stat_unmasked; // RULE10
         dcb_ff <= stat_unmasked;
      end
   end

   assign adc_cell_ov_flags = aov_ff;
   assign adc_cell_uv_flags = auv_ff;
   assign comparator_cell_ov_flags = cov_ff;
   assign comparator_cell_uv_flags = cuv_ff;
   assign adc_aux_ov_flags = xaov_ff;
   assign adc_aux_uv_flags = xauv_ff;
   assign comparator_aux_ov_flags = xcov_ff;
   assign comparator_aux_uv_flags = xcuv_ff;
   assign alert_summary_register = summ_ff;
   assign primary_status_register = stat_ff;
   assign hw_alert_out = alert_ff;
   assign data_check_alerts = dcb_ff;
   assign lowest_cell_index = min_idx_ff;
   assign highest_cell_index = max_idx_ff;
   assign cell_sum = sum_ff;
   assign reg_rdata = rdata_ff;

   // ==========================================
   // assertions
   a_summary_or_adc: assert property (@(posedge mclk) disable iff (sys_rst) // RULE6
      summ_ff[SUM_ADC_OV] == |aov_ff) else $error("adc ov summary mismatch");
   a_summary_or_cmp: assert property (@(posedge mclk) disable iff (sys_rst) // RULE7
      summ_ff[SUM_CMP_UV] == |cuv_ff) else $error("cmp uv summary mismatch");
   a_status_cell_ov: assert property (@(posedge mclk) disable iff (sys_rst) // RULE8
      stat_ff[ST_CELL_OV] == (|aov_ff | |cov_ff)) else $error("status cell ov wrong");
   a_status_aux_uv: assert property (@(posedge mclk) disable iff (sys_rst) // RULE23
      stat_ff[ST_AUX_UV] == (|xauv_ff | |xcuv_ff)) else $error("status aux uv wrong");
   a_flags_hold_idle: assert property (@(posedge mclk) disable iff (sys_rst) // RULE25
      !acq.done |=> $stable(stat_ff) && $stable(aov_ff)) else $error("flags moved");
   a_disabled_no_flag: assert property (@(posedge mclk) disable iff (sys_rst) // RULE1
      acq.done && !cell_enable[0] |=> !aov_ff[0] && !cov_ff[0]) else $error("disabled flag");
   a_stats_hold_empty: assert property (@(posedge mclk) disable iff (sys_rst) // RULE15
      acq.done && cell_enable == '0 |=> $stable(sum_ff) && $stable(min_idx_ff))
      else $error("stats changed with no cells");
   a_mask_blocks_alert: assert property (@(posedge mclk) disable iff (sys_rst) // RULE10
      (stat_ff & ~status_mask) == '0 |=> !hw_alert_out) else $error("masked alert leaked");
   a_mismatch_reset: assert property (@(posedge mclk) // RULE13
      sys_rst |=> mismatch_threshold_ff == MISMATCH_THR_RST) else $error("bad msm reset");
   c_cell_ov: cover property (@(posedge mclk) disable iff (sys_rst) $rose(stat_ff[ST_CELL_OV]));
   c_mismatch: cover property (@(posedge mclk) disable iff (sys_rst) $rose(msm_ff));
   c_aux_uv: cover property (@(posedge mclk) disable iff (sys_rst) $rose(stat_ff[ST_AUX_UV]));
   c_alert: cover property (@(posedge mclk) disable iff (sys_rst) $rose(hw_alert_out));
endmodule

// *** tb/acq_source.sv ***
`timescale 1ns/1ps
module acq_source
   import cell_alert_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // request from the bench
   input wire logic fire,
   input wire acq_t payload,
   // towards the block
   output acq_t acq
);
   // ==========================================
   // result for one cycle, scrambled data otherwise
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acq <= '0;
      end else if (fire) begin
         acq <= payload;
         acq.done <= 1'b1;
      end else begin
         acq <= ~acq;
         acq.done <= 1'b0;
      end
   end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb
   import cell_alert_pkg::*;
;
   localparam hyst_thr_t CT = '{16'h3050, 16'h3020, 16'h3010, 16'h3030};
   localparam hyst_thr_t BT = '{16'h3058, 16'h3028, 16'h3008, 16'h3038};
   localparam hyst_thr_t AT = '{16'h3070, 16'h3060, 16'h3040, 16'h3050};
   localparam cmp_thr_t CC = '{16'h3048, 16'h3018};
   localparam cmp_thr_t CA = '{16'h3068, 16'h3048};
   // ==========================================
   // signals
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic fire = 1'b0;
   acq_t payload = '0;
   acq_t acq;
   logic [NUM_CELLS-1:0] cell_enable, cell_bipolar, cell_ov_alert_enable, cell_uv_alert_enable;
   logic block_ov_alert_enable, block_uv_alert_enable, filtered_read_select;
   logic statistics_polarity_select, reg_wr, reg_rd, hw_alert_out, e_bov, e_buv, e_mm;
   hyst_thr_t cell_thr, bipolar_thr, block_thr, aux_ratio_thr, aux_abs_thr;
   cmp_thr_t comparator_cell_thr, comparator_aux_ratio_thr, comparator_aux_abs_thr;
   logic [NUM_AUX-1:0] aux_enable, aux_ov_alert_enable, aux_uv_alert_enable, aux_reference_select;
   logic [3:0] reg_addr;
   logic [MSM_W-1:0] reg_wdata, reg_rdata, mm_thr, rd;
   logic [ST_W-1:0] status_mask, primary_status_register, data_check_alerts;
   logic [NUM_CELLS-1:0] adc_cell_ov_flags, adc_cell_uv_flags, comparator_cell_ov_flags;
   logic [NUM_CELLS-1:0] comparator_cell_uv_flags, e_aov, e_auv, e_cov, e_cuv;
   logic [NUM_AUX-1:0] adc_aux_ov_flags, adc_aux_uv_flags, comparator_aux_ov_flags;
   logic [NUM_AUX-1:0] comparator_aux_uv_flags, e_xov, e_xuv, e_yov, e_yuv;
   logic [SUM_W-1:0] alert_summary_register;
   logic [IDX_W-1:0] lowest_cell_index, highest_cell_index, e_lo, e_hi;
   logic [DATA_W-1:0] cell_sum, e_sum;
   logic [DATA_W-1:0] raw4 [4] = '{16'h2000, 16'h2000, 16'hF000, 16'h2800};
   logic [DATA_W-1:0] filt4 [4] = '{16'h1000, 16'h3000, 16'h1000, 16'h3000};
   int mismatches = 0;
   int n_compared = 0;
   int seed = 94593;

   cell_alert_statistics u_cell_alert_statistics (.*);
   acq_source u_acq_source (.*);

   always #2 mclk = ~mclk;

   // ==========================================
   // checking helpers
   function automatic logic hy(input logic p, input logic [15:0] v, s, c, input logic ov);
      if (ov) return (v > s) ? 1'b1 : (v < c) ? 1'b0 : p;
      return (v < s) ? 1'b1 : (v > c) ? 1'b0 : p;
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic model_step();
      hyst_thr_t t;
      cmp_thr_t c;
      logic [DATA_W-1:0] v, w, s;
      logic g, any_en, like;
      logic signed [DATA_W:0] mn, mx, x;
      any_en = 1'b0;
      like = 1'b0;
      s = '0;
      mn = '0;
      mx = '0;
      c = comparator_cell_thr;
      for (int i = 0; i < NUM_CELLS; i++) begin
         t = cell_bipolar[i] ? bipolar_thr : cell_thr;
         v = payload.cell_raw[i];
         w = payload.cell_cmp[i];
         g = cell_enable[i] & cell_ov_alert_enable[i];
         e_aov[i] = g & hy(e_aov[i], v, t.ov_set, t.ov_clr, 1'b1);
         e_cov[i] = g & hy(e_cov[i], w, c.ov, c.ov, 1'b1);
         g = cell_enable[i] & cell_uv_alert_enable[i];
         e_auv[i] = g & hy(e_auv[i], v, t.uv_set, t.uv_clr, 1'b0);
         e_cuv[i] = g & hy(e_cuv[i], w, c.uv, c.uv, 1'b0);
         v = filtered_read_select ? payload.cell_filt[i] : v;
         x = {v[15], v};
         if (cell_enable[i]) begin
            any_en = 1'b1;
            s = s + v;
            if (cell_bipolar[i] == statistics_polarity_select) begin
               if (!like || x < mn) begin
                  mn = x;
                  e_lo = IDX_W'(i + 1);
               end
               if (!like || x > mx) begin
                  mx = x;
                  e_hi = IDX_W'(i + 1);
               end
               like = 1'b1;
            end
         end
      end
      if (any_en) e_sum = s;
      e_mm = like && (mx - mn > $signed({3'b000, mm_thr}));
      t = block_thr;
      v = payload.block_v;
      e_bov = block_ov_alert_enable & hy(e_bov, v, t.ov_set, t.ov_clr, 1'b1);
      e_buv = block_uv_alert_enable & hy(e_buv, v, t.uv_set, t.uv_clr, 1'b0);
      for (int j = 0; j < NUM_AUX; j++) begin
         t = aux_reference_select[j] ? aux_ratio_thr : aux_abs_thr;
         c = aux_reference_select[j] ? comparator_aux_ratio_thr : comparator_aux_abs_thr;
         v = payload.aux_adc[j];
         w = payload.aux_cmp[j];
         g = aux_enable[j] & aux_ov_alert_enable[j];
         e_xov[j] = g & hy(e_xov[j], v, t.ov_set, t.ov_clr, 1'b1);
         e_yov[j] = g & hy(e_yov[j], w, c.ov, c.ov, 1'b1);
         g = aux_enable[j] & aux_uv_alert_enable[j];
         e_xuv[j] = g & hy(e_xuv[j], v, t.uv_set, t.uv_clr, 1'b0);
         e_yuv[j] = g & hy(e_yuv[j], w, c.uv, c.uv, 1'b0);
      end
   endtask

   task automatic acquire(input bit stats_only);
      logic [ST_W-1:0] st;
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      model_step();
      repeat (2) @(posedge mclk);
      #1;
      st = {e_mm, |{e_xuv, e_yuv}, |{e_xov, e_yov}, e_buv, e_bov,
         |{e_auv, e_cuv}, |{e_aov, e_cov}};
      chk("lowest index", e_lo, lowest_cell_index);
      chk("highest index", e_hi, highest_cell_index);
      chk("cell sum", e_sum, cell_sum);
      if (!stats_only) begin
         chk("adc cell ov", e_aov, adc_cell_ov_flags);
         chk("adc cell uv", e_auv, adc_cell_uv_flags);
         chk("cmp cell ov", e_cov, comparator_cell_ov_flags);
         chk("cmp cell uv", e_cuv, comparator_cell_uv_flags);
         chk("adc aux ov", e_xov, adc_aux_ov_flags);
         chk("adc aux uv", e_xuv, adc_aux_uv_flags);
         chk("cmp aux ov", e_yov, comparator_aux_ov_flags);
         chk("cmp aux uv", e_yuv, comparator_aux_uv_flags);
         chk("summary", {|e_yuv, |e_yov, |e_xuv, |e_xov, |e_cuv, |e_cov, |e_auv, |e_aov},
            alert_summary_register);
         chk("status", st, primary_status_register);
         chk("data check", st & ~status_mask, data_check_alerts);
         chk("alert out", |(st & ~status_mask), hw_alert_out);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [MSM_W-1:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [MSM_W-1:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // ==========================================
   // main sequence
   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      logic [DATA_W-1:0] v, d;
      {cell_enable, cell_bipolar, cell_ov_alert_enable, cell_uv_alert_enable} = '0;
      {aux_enable, aux_ov_alert_enable, aux_uv_alert_enable, aux_reference_select} = '0;
      {block_ov_alert_enable, block_uv_alert_enable, filtered_read_select} = '0;
      {statistics_polarity_select, reg_wr, reg_rd, reg_addr, reg_wdata, status_mask} = '0;
      {cell_thr, bipolar_thr, block_thr, aux_ratio_thr, aux_abs_thr} = {CT, BT, CT, CT, AT};
      {comparator_cell_thr, comparator_aux_ratio_thr, comparator_aux_abs_thr} = {CC, CC, CA};
      {e_aov, e_auv, e_cov, e_cuv, e_xov, e_xuv, e_yov, e_yuv} = '0;
      {e_bov, e_buv, e_mm, e_lo, e_hi, e_sum} = '0;
      mm_thr = 14'h3FFF;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      reg_read(4'h0, rd);
      chk("status after reset", 0, primary_status_register);
      chk("mismatch threshold reset", 14'h3FFF, rd);
      reg_write(4'h1, 14'h1555);
      reg_read(4'h1, rd);
      chk("status read-only", 0, rd);
      reg_read(4'h9, rd);
      chk("unmapped read", 0, rd);
      mm_thr = 14'h0040;
      reg_write(4'h0, mm_thr);
      reg_read(4'h0, rd);
      chk("mismatch threshold", mm_thr, rd);
      $display("register test done");
      for (int k = 0; k < 80; k++) begin
         @(posedge mclk);
         d = 16'($random(seed) & 31);
         cell_thr <= CT + {4{d}};
         bipolar_thr <= BT + {4{d}};
         block_thr <= CT + {4{d}};
         aux_ratio_thr <= CT + {4{d}};
         aux_abs_thr <= AT + {4{d}};
         comparator_cell_thr <= CC + {2{d}};
         comparator_aux_ratio_thr <= CC + {2{d}};
         comparator_aux_abs_thr <= CA + {2{d}};
         cell_enable <= NUM_CELLS'($random(seed));
         cell_bipolar <= NUM_CELLS'($random(seed));
         cell_ov_alert_enable <= NUM_CELLS'($random(seed));
         cell_uv_alert_enable <= NUM_CELLS'($random(seed));
         aux_enable <= NUM_AUX'($random(seed));
         aux_ov_alert_enable <= NUM_AUX'($random(seed));
         aux_uv_alert_enable <= NUM_AUX'($random(seed));
         aux_reference_select <= NUM_AUX'($random(seed));
         {block_ov_alert_enable, block_uv_alert_enable} <= 2'($random(seed));
         {filtered_read_select, statistics_polarity_select} <= 2'($random(seed));
         status_mask <= ST_W'($random(seed));
         for (int i = 0; i < NUM_CELLS; i++) begin
            v = 16'h3000 + d + 16'($random(seed) & 127);
            payload.cell_raw[i] <= v;
            payload.cell_filt[i] <= v;
            payload.cell_cmp[i] <= 16'h3000 + d + 16'($random(seed) & 127);
         end
         for (int j = 0; j < NUM_AUX; j++) begin
            payload.aux_adc[j] <= 16'h3000 + d + 16'($random(seed) & 127);
            payload.aux_cmp[j] <= 16'h3000 + d + 16'($random(seed) & 127);
         end
         payload.block_v <= 16'h3000 + d + 16'($random(seed) & 127);
         acquire(1'b0);
      end
      reg_read(4'h1, rd);
      chk("status over bus", e_mm ? 1 : 0, rd[ST_MSMTCH]);
      reg_read(4'h2, rd);
      chk("indices over bus", {e_hi, e_lo}, rd);
      reg_read(4'h3, rd);
      chk("sum over bus", e_sum[MSM_W-1:0], rd);
      $display("random alert test done");
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         cell_enable <= (k == 3) ? 14'h0000 : 14'h000F;
         cell_bipolar <= 14'h0004;
         filtered_read_select <= (k == 1);
         statistics_polarity_select <= (k == 2);
         for (int i = 0; i < NUM_CELLS; i++) begin
            payload.cell_raw[i] <= (i < 4) ? raw4[i % 4] : 16'h0000;
            payload.cell_filt[i] <= (i < 4) ? filt4[i % 4] : 16'h0000;
         end
         acquire(1'b1);
      end
      $display("statistics test done");
      tally_and_finish();
   end
endmodule
